/* File: verilog/twc_port_map.vh */
// constants for the three-wire configuration port
`ifndef TWC_PORT_MAP_VH
`define TWC_PORT_MAP_VH
`define TWC_WORD_BITS      32
`define TWC_ADDR_BITS      5
`define TWC_DATA_BITS      27
`define TWC_REG_COUNT      32
`define TWC_DATA_RESET     27'h0000000
`define TWC_SYNC_EN_RESET  1'b0
`define TWC_SYNC_PULSE_NS  10
`define TWC_CLK_PERIOD_NS  5
`define TWC_SYNC_PULSE_CYC ((`TWC_SYNC_PULSE_NS + `TWC_CLK_PERIOD_NS - 1) / `TWC_CLK_PERIOD_NS)
`endif

/* File: verilog/twc_sync2.v */
// two flip-flop synchroniser for a level from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module twc_sync2 #(
    parameter RST_VAL = 1'b0
) (
    input  wire clk_i,    // system clock
    input  wire rst_n_i,  // async reset, active low
    input  wire d_i,      // asynchronous level
    output reg  q_o       // synchronised level
);
    reg meta_reg;
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_reg <= RST_VAL;
            q_o      <= RST_VAL;
        end else begin
            meta_reg <= d_i;
            q_o      <= meta_reg;
        end
    end
endmodule // twc_sync2
`default_nettype wire

/* File: verilog/twc_port.v */
// three-wire serial configuration port: shift, latch, decode, auto sync
`timescale 1ns/1ps
`default_nettype none
`include "twc_port_map.vh"
//
// Contract
// - each serial clock rising edge shifts the data pin into the word
// - latch-enable rising edge copies the word into the addressed register
// - with auto sync set, latch-enable falling edge makes a sync pulse
// - shifting continues on every serial clock rising edge during readback
// - latch-enable rising after readback writes the shifted word
// - the address is the last five bits shifted before latching
module twc_port #(
    parameter WORD_BITS = `TWC_WORD_BITS,
    parameter ADDR_BITS = `TWC_ADDR_BITS,
    parameter DATA_BITS = `TWC_DATA_BITS,
    parameter REG_COUNT = `TWC_REG_COUNT,
    parameter SYNC_CYC  = `TWC_SYNC_PULSE_CYC
) (
    input  wire                 clk_i,                // 200 MHz clock
    input  wire                 rst_n_i,              // async reset, low
    input  wire                 serial_clock_pin_i,   // host serial clock
    input  wire                 serial_data_pin_i,    // host serial data
    input  wire                 latch_enable_pin_i,   // host latch enable
    input  wire                 auto_sync_en_i,       // auto sync setting
    input  wire [ADDR_BITS-1:0] rd_addr_i,            // register view select
    output reg  [DATA_BITS-1:0] rd_data_o,            // selected register
    output reg                  write_strobe_o,       // one-cycle write pulse
    output reg  [ADDR_BITS-1:0] write_addr_o,         // address written
    output reg  [DATA_BITS-1:0] write_data_o,         // data written
    output reg                  sync_pulse_o,         // generated sync event
    output reg  [WORD_BITS-1:0] shift_word_o          // live shift register
);
    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    wire sclk_s;
    wire sdat_s;
    wire le_s;
    twc_sync2 #(.RST_VAL(1'b0)) u_sclk (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .d_i     (serial_clock_pin_i),
        .q_o     (sclk_s)
    );
    twc_sync2 #(.RST_VAL(1'b0)) u_sdat (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .d_i     (serial_data_pin_i),
        .q_o     (sdat_s)
    );
    twc_sync2 #(.RST_VAL(1'b0)) u_le (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .d_i     (latch_enable_pin_i),
        .q_o     (le_s)
    );
    // ----------------------------------------------------------------
    // edge detection
    // ----------------------------------------------------------------
    reg  sclk_d_reg;
    reg  le_d_reg;
    wire sclk_rise = sclk_s & ~sclk_d_reg;
    wire le_rise   = le_s & ~le_d_reg;
    wire le_fall   = ~le_s & le_d_reg;
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sclk_d_reg <= 1'b0;
            le_d_reg   <= 1'b0;
        end else begin
            sclk_d_reg <= sclk_s;
            le_d_reg   <= le_s;
        end
    end
    // ----------------------------------------------------------------
    // word field helpers
    // ----------------------------------------------------------------
    // address field: the last bits shifted in sit at the bottom
    function [ADDR_BITS-1:0] word_addr;
        input [WORD_BITS-1:0] word;
        begin
            word_addr = word[ADDR_BITS-1:0];
        end
    endfunction
    // data field: everything above the address
    function [DATA_BITS-1:0] word_data;
        input [WORD_BITS-1:0] word;
        begin
            word_data = word[WORD_BITS-1:ADDR_BITS];
        end
    endfunction
    // one bit enters at the bottom, the oldest bit drops off the top
    function [WORD_BITS-1:0] word_shift;
        input [WORD_BITS-1:0] word;
        input                 bit_in;
        begin
            word_shift = {word[WORD_BITS-2:0], bit_in};
        end
    endfunction
    // sync length cut to the counter width, never below one cycle
    function [7:0] sync_len;
        input integer cyc;
        begin
            if (cyc < 1) begin
                sync_len = 8'h01;
            end else begin
                sync_len = cyc[7:0];
            end
        end
    endfunction
    // ----------------------------------------------------------------
    // shift register
    // ----------------------------------------------------------------
    reg [WORD_BITS-1:0] shift_next;
    always @* begin
        shift_next = shift_word_o;
        // shifting goes on whatever latch enable does, readback too
        if (sclk_rise) begin
            shift_next = word_shift(shift_word_o, sdat_s);
        end
    end
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            shift_word_o <= {WORD_BITS{1'b0}};
        end else begin
            shift_word_o <= shift_next;
        end
    end
    // ----------------------------------------------------------------
    // latch decode and register file
    // ----------------------------------------------------------------
    reg  [DATA_BITS-1:0] regs_mem [0:REG_COUNT-1];
    wire [ADDR_BITS-1:0] dec_addr = word_addr(shift_word_o);
    wire [DATA_BITS-1:0] dec_data = word_data(shift_word_o);
    integer i;
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (i = 0; i < REG_COUNT; i = i + 1) begin
                regs_mem[i] <= `TWC_DATA_RESET;
            end
        end else begin
            if (le_rise) begin
                regs_mem[dec_addr] <= dec_data;
            end
        end
    end
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            write_strobe_o <= 1'b0;
            write_addr_o   <= {ADDR_BITS{1'b0}};
            write_data_o   <= `TWC_DATA_RESET;
        end else begin
            write_strobe_o <= le_rise;
            if (le_rise) begin
                write_addr_o <= dec_addr;
                write_data_o <= dec_data;
            end
        end
    end
    // view port: one cycle behind the select
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rd_data_o <= `TWC_DATA_RESET;
        end else begin
            rd_data_o <= regs_mem[rd_addr_i];
        end
    end
    // ----------------------------------------------------------------
    // automatic sync on latch-enable falling edge
    // ----------------------------------------------------------------
    localparam [1:0] SYNC_IDLE  = 2'b01;
    localparam [1:0] SYNC_PULSE = 2'b10;
    reg [1:0] sync_state_reg;
    reg [1:0] sync_state_next;
    reg [7:0] sync_cnt_reg;
    reg [7:0] sync_cnt_next;
    reg       sync_pulse_next;
    always @* begin
        sync_state_next = sync_state_reg;
        sync_cnt_next   = sync_cnt_reg;
        sync_pulse_next = 1'b0;
        case (sync_state_reg)
            SYNC_IDLE: begin
                if (le_fall && auto_sync_en_i) begin
                    sync_state_next = SYNC_PULSE;
                    sync_cnt_next   = sync_len(SYNC_CYC);
                    sync_pulse_next = 1'b1;
                end
            end
            SYNC_PULSE: begin
                if (sync_cnt_reg > 8'h01) begin
                    sync_cnt_next   = sync_cnt_reg - 8'h01;
                    sync_pulse_next = 1'b1;
                end else begin
                    sync_state_next = SYNC_IDLE;
                    sync_cnt_next   = 8'h00;
                end
            end
            default: begin
                sync_state_next = SYNC_IDLE;
                sync_cnt_next   = 8'h00;
            end
        endcase
    end
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sync_state_reg <= SYNC_IDLE;
            sync_cnt_reg   <= 8'h00;
            sync_pulse_o   <= 1'b0;
        end else begin
            sync_state_reg <= sync_state_next;
            sync_cnt_reg   <= sync_cnt_next;
            sync_pulse_o   <= sync_pulse_next;
        end
    end
endmodule // twc_port
`default_nettype wire

/* File: sim/twc_port_chk_sva.sv */
// assertions for the three-wire configuration port
`timescale 1ns/1ps
`default_nettype none
module twc_port_chk (
    input wire logic        clk_i,              // system clock
    input wire logic        rst_n_i,            // async reset, low
    input wire logic        serial_clock_pin_i, // host serial clock
    input wire logic        serial_data_pin_i,  // host serial data
    input wire logic        latch_enable_pin_i, // host latch enable
    input wire logic        auto_sync_en_i,     // auto sync setting
    input wire logic        write_strobe_o,     // write pulse
    input wire logic        sync_pulse_o,       // sync event
    input wire logic [4:0]  rd_addr_i,          // view select
    input wire logic [4:0]  write_addr_o,       // address written
    input wire logic [26:0] rd_data_o,          // view data
    input wire logic [26:0] write_data_o,       // data written
    input wire logic [31:0] shift_word_o        // live shift register
);
    wire sck = serial_clock_pin_i;
    wire sd = serial_data_pin_i;
    wire le = latch_enable_pin_i;
    wire [31:0] w = shift_word_o;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    shift_in_a: assert property ($rose(sck) |-> ##3
        w == {$past(w[30:0]), $past(sd, 3)}) else $error("bad shift");
    le_write_a: assert property ($rose(le) |-> ##3
        write_strobe_o && write_addr_o == $past(w[4:0]) &&
        write_data_o == $past(w[31:5])) else $error("bad latch");
    auto_sync_a: assert property ($fell(le) |-> ##3
        sync_pulse_o == $past(auto_sync_en_i, 3)) else $error("bad sync");
    reg_view_a: assert property (write_strobe_o &&
        rd_addr_i == write_addr_o |=> rd_data_o == $past(write_data_o))
        else $error("bad view");
    strobe_single_a: assert property (write_strobe_o |=>
        !write_strobe_o) else $error("strobe too long");
    sync_width_a: assert property ($rose(sync_pulse_o) |=>
        sync_pulse_o ##1 !sync_pulse_o) else $error("bad sync width");
    cover property (write_strobe_o);
    cover property (sync_pulse_o);
    cover property ($rose(sck) && le);
endmodule // twc_port_chk
bind twc_port twc_port_chk u_chk (.*);
`default_nettype wire

/* File: sim/twc_host.sv */
// host model driving the three-wire serial lines
`timescale 1ns/1ps
`default_nettype none
module twc_host (
    input  wire logic clk_i,  // bench clock
    output logic      sclk_o, // serial clock
    output logic      sdat_o, // serial data
    output logic      le_o    // latch enable
);
    initial {sclk_o, sdat_o, le_o} = 3'h0;
    task automatic send(input logic [31:0] w, input int n, input logic l);
        for (int i = n - 1; i >= 0; i--) begin
            sdat_o = w[i];
            repeat (8) @(negedge clk_i);
            sclk_o = 1'b1;
            repeat (8) @(negedge clk_i);
            sclk_o = 1'b0;
        end
        sdat_o = 1'b0;
        repeat (8) @(negedge clk_i);
        le_o = l;
    endtask
endmodule // twc_host
`default_nettype wire

/* File: sim/twc_port_tb.sv */
// bench for the three-wire configuration port
`timescale 1ns/1ps
`default_nettype none
module twc_port_tb;
    logic clk_i = 1'b0, rst_n_i = 1'b0, auto_sync_en_i = 1'b0, sync_pulse_o;
    logic serial_clock_pin_i, serial_data_pin_i, latch_enable_pin_i;
    logic write_strobe_o;
    logic [4:0] rd_addr_i = 5'h00, write_addr_o;
    logic [26:0] rd_data_o, write_data_o;
    logic [31:0] shift_word_o;
    int fail_count = 0, checked = 0;
    always #2.5 clk_i = ~clk_i;
    twc_host u_host (.clk_i, .sclk_o(serial_clock_pin_i),
        .sdat_o(serial_data_pin_i), .le_o(latch_enable_pin_i));
    twc_port DUT (.*);
    task automatic check(input string s, input logic [31:0] v, e);
        checked++;
        if (v !== e) $display("MISMATCH %s expected %h seen %h", s, e, v);
        fail_count += int'(v !== e);
    endtask
    task automatic complete_run(input int late);
        fail_count += late;
        $display("checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // word, latch high, three extra clocks, latch low
    task automatic t_program(input logic [31:0] w, input logic en);
        auto_sync_en_i = en;
        u_host.send(w, 32, 1'b1);
        u_host.send(32'h5, 3, 1'b0);
        repeat (4) @(negedge clk_i);
        check("sync", sync_pulse_o, en);
        check("addr", write_addr_o, w[4:0]);
        check("shift", shift_word_o, {w[28:0], 3'h5});
        check("data", write_data_o, w[31:5]);
        check("strobe", write_strobe_o, 1'b0);
        rd_addr_i = w[4:0];
        repeat (2) @(negedge clk_i);
        check("view", rd_data_o, w[31:5]);
    endtask
    initial begin
        repeat (10) @(negedge clk_i);
        rst_n_i = 1'b1;
        t_program(32'hffffffff, 1'b1);
        t_program(32'h00000020, 1'b0);
        complete_run(0);
    end
    initial #100000 complete_run(1);
endmodule // twc_port_tb
`default_nettype wire
